/* File: core/iomb_exec.sv */
// module: execute slice for increment, skip, branch, or and move instructions
// =====================================================================
module iomb_exec
    import iomb_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // instruction issue, one per instruction cycle enable
    input wire logic cyc_en,
    input wire logic insn_valid,
    input wire logic [13:0] insn,
    // file register read data for the addressed register
    input wire logic [7:0] file_rdata,
    input wire logic [7:0] page_latch,
    // file register access
    output logic [6:0] file_addr,
    output logic file_we,
    output logic [7:0] file_wdata,
    // architectural state
    output logic [7:0] acc,
    output logic zero_flag,
    output logic [12:0] program_counter,
    // sequencing
    output logic squash_next,
    output logic busy,
    output logic illegal
);

    // =====================================================================
    // state
    typedef struct packed {
        logic [7:0] acc;
        logic zero;
        logic [12:0] pc;
        logic [6:0] faddr;
        logic fwe;
        logic [7:0] fwdata;
        logic squash;
        logic bubble;
        logic illegal;
    } iomb_state_s;

    iomb_state_s st_q;
    iomb_state_s st_d;
    iomb_op_e op;
    logic dest_file;

    iomb_alu_if alu_bus ();

    iomb_alu u_alu (
        .a(alu_bus)
    );

    // =====================================================================
    // decode; the file address is always the low seven bits
    always_comb begin
        op = IOMB_NONE;
        if (insn[13:8] == IOMB_OP_INC_SKIP) begin
            op = IOMB_INC_SKIP;
        end else if (insn[13:8] == IOMB_OP_INC_FILE) begin
            op = IOMB_INC_FILE;
        end else if (insn[13:8] == IOMB_OP_OR_FILE) begin
            op = IOMB_OR_FILE;
        end else if (insn[13:8] == IOMB_OP_MOVE_FILE) begin
            op = IOMB_MOVE_FILE;
        end else if (insn[13:10] == IOMB_OP_OR_LIT[5:2]) begin
            op = IOMB_OR_LIT; // low two opcode bits are don't care
        end else if (insn[13:11] == IOMB_OP_BRANCH) begin
            op = IOMB_BRANCH;
        end
    end

    assign dest_file = insn[IOMB_DEST_BIT];

    assign alu_bus.op = op;
    assign alu_bus.acc = st_q.acc;
    assign alu_bus.file = file_rdata;
    assign alu_bus.lit = insn[7:0];

    // =====================================================================
    // next state
    always_comb begin
        st_d = st_q;
        st_d.fwe = 1'b0;
        if (cyc_en) begin
            st_d.squash = 1'b0;
            st_d.bubble = 1'b0;
            st_d.illegal = 1'b0;
            // a squashed or bubbled slot is a no-operation
            if (insn_valid && !st_q.squash && !st_q.bubble) begin
                st_d.pc = st_q.pc + 13'h0001;
                st_d.faddr = insn[6:0];
                st_d.fwdata = alu_bus.result;
                unique case (op)
                    IOMB_INC_SKIP: begin
                        // zero result costs a second cycle; flags untouched
                        st_d.squash = alu_bus.is_zero;
                        if (dest_file) begin
                            st_d.fwe = 1'b1;
                        end else begin
                            st_d.acc = alu_bus.result;
                        end
                    end
                    IOMB_INC_FILE, IOMB_OR_FILE, IOMB_MOVE_FILE: begin
                        // move with dest 1 rewrites the same value: file intact
                        if (dest_file) begin
                            st_d.fwe = 1'b1;
                        end else begin
                            st_d.acc = alu_bus.result;
                        end
                        st_d.zero = alu_bus.is_zero;
                    end
                    IOMB_OR_LIT: begin
                        st_d.acc = alu_bus.result;
                        st_d.zero = alu_bus.is_zero;
                    end
                    IOMB_BRANCH: begin
                        // page bits from latch, offset from immediate
                        st_d.pc = {page_latch[IOMB_PAGE_HI:IOMB_PAGE_LO],
                                   insn[IOMB_LIT_W-1:0]};
                        st_d.bubble = 1'b1; // second cycle, zero kept
                    end
                    default: begin
                        st_d.illegal = 1'b1; // outside this slice
                    end
                endcase
            end else if (insn_valid) begin
                st_d.pc = st_q.pc + 13'h0001; // skipped word still advances
            end
        end
    end

    // =====================================================================
    // registers
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '{acc: IOMB_RST_ACC, zero: IOMB_RST_ZERO, pc: IOMB_RST_PC,
                      faddr: 7'h00, fwe: 1'b0, fwdata: 8'h00, squash: 1'b0,
                      bubble: 1'b0, illegal: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    // outputs straight from flip-flops, except busy, the OR of the squash and bubble flops
    assign file_addr = st_q.faddr;
    assign file_we = st_q.fwe;
    assign file_wdata = st_q.fwdata;
    assign acc = st_q.acc;
    assign zero_flag = st_q.zero;
    assign program_counter = st_q.pc;
    assign squash_next = st_q.squash;
    assign busy = st_q.squash | st_q.bubble; // marks the second instruction cycle
    assign illegal = st_q.illegal;

endmodule : iomb_exec

/* File: core/iomb_pkg.sv */
// package: opcodes, field positions, widths and reset values of the execute slice
package iomb_pkg;

    // =====================================================================
    // widths
    localparam int IOMB_INSN_W = 14;
    localparam int IOMB_DATA_W = 8;
    localparam int IOMB_ADDR_W = 7;
    localparam int IOMB_PC_W = 13;
    localparam int IOMB_LIT_W = 11;

    // =====================================================================
    // field positions: destination bit in the instruction word, page bits in the page latch
    localparam int IOMB_DEST_BIT = 7;
    localparam int IOMB_PAGE_LO = 3;
    localparam int IOMB_PAGE_HI = 4;

    // =====================================================================
    // opcode patterns: top six bits for file forms, top three for branch
    localparam logic [5:0] IOMB_OP_INC_SKIP = 6'h0f;
    localparam logic [5:0] IOMB_OP_INC_FILE = 6'h0a;
    localparam logic [5:0] IOMB_OP_OR_FILE = 6'h04;
    localparam logic [5:0] IOMB_OP_MOVE_FILE = 6'h08;
    localparam logic [5:0] IOMB_OP_OR_LIT = 6'h38;
    localparam logic [2:0] IOMB_OP_BRANCH = 3'h5;

    // =====================================================================
    // reset values and cycle counts
    localparam logic [7:0] IOMB_RST_ACC = 8'h00;
    localparam logic [12:0] IOMB_RST_PC = 13'h0000;
    localparam logic IOMB_RST_ZERO = 1'b0;
    localparam int IOMB_CYC_SINGLE = 1;
    localparam int IOMB_CYC_DOUBLE = 2;

    // decoded operation
    typedef enum logic [2:0] {
        IOMB_NONE,
        IOMB_INC_SKIP,
        IOMB_INC_FILE,
        IOMB_BRANCH,
        IOMB_OR_LIT,
        IOMB_OR_FILE,
        IOMB_MOVE_FILE
    } iomb_op_e;

endpackage : iomb_pkg

/* File: core/iomb_alu_if.sv */
// interface: operands and results between the decoder and its alu
interface iomb_alu_if;
    import iomb_pkg::*;

    iomb_op_e op;
    logic [7:0] acc;
    logic [7:0] file;
    logic [7:0] lit;
    logic [7:0] result;
    logic is_zero;

    modport ctrl (output op, output acc, output file, output lit, input result, input is_zero);
    modport alu (input op, input acc, input file, input lit, output result, output is_zero);
endinterface : iomb_alu_if

/* File: core/iomb_alu.sv */
// module: combinational datapath for increment, or and move
module iomb_alu
    import iomb_pkg::*;
(
    // operands and results
    iomb_alu_if.alu a
);

    // =====================================================================
    // result select
    always_comb begin
        unique case (a.op)
            IOMB_INC_SKIP, IOMB_INC_FILE: a.result = a.file + 8'h01; // wraps 0xff to 0
            IOMB_OR_LIT: a.result = a.acc | a.lit;
            IOMB_OR_FILE: a.result = a.acc | a.file;
            IOMB_MOVE_FILE: a.result = a.file;
            default: a.result = 8'h00;
        endcase
    end

    // zero detect on the eight bit result
    assign a.is_zero = (a.result == 8'h00);

endmodule : iomb_alu

/* File: verification/iomb_exec_chk.sv */
// checker: cycle relations between taken instructions and results
module iomb_exec_chk
    import iomb_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // issue side
    input wire logic cyc_en,
    input wire logic insn_valid,
    input wire logic [13:0] insn,
    input wire logic [7:0] file_rdata,
    input wire logic [7:0] page_latch,
    // results
    input wire logic file_we,
    input wire logic [7:0] file_wdata,
    input wire logic [7:0] acc,
    input wire logic zero_flag,
    input wire logic [12:0] program_counter,
    input wire logic squash_next,
    input wire logic busy
);
    // =====================================================================
    // an instruction counts only when it lands outside a busy slot
    default clocking @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    wire logic tk = cyc_en && insn_valid && !busy;
    wire logic [5:0] op = insn[13:8];
    wire logic d1 = insn[7];

    // zero skip, then the following issue two edges on
    sequence s_skip_zero;
        tk && op == IOMB_OP_INC_SKIP && file_rdata == 8'hff;
    endsequence
    sequence s_next_slot;
        s_skip_zero ##2 (cyc_en && op != IOMB_OP_INC_SKIP);
    endsequence

    a_skip_squash: assert property (s_skip_zero |=> squash_next && busy && $stable(zero_flag))
        else $error("zero skip did not squash");
    a_skip_one_slot: assert property (s_next_slot |=> !squash_next)
        else $error("squash lasted too long");
    a_skip_dest: assert property (tk && op == IOMB_OP_INC_SKIP && d1 |=> file_we && file_wdata == $past(file_rdata) + 8'h01)
        else $error("skip write-back wrong");
    a_inc_zero: assert property (tk && op == IOMB_OP_INC_FILE && !d1 |=> acc == $past(file_rdata) + 8'h01 && zero_flag == (acc == 8'h00))
        else $error("increment result wrong");
    a_branch_pc: assert property (tk && insn[13:11] == IOMB_OP_BRANCH |=> program_counter == {$past(page_latch[4:3]), $past(insn[10:0])} && busy && $stable(zero_flag))
        else $error("branch target wrong");
    a_or_lit: assert property (tk && op == IOMB_OP_OR_LIT |=> acc == ($past(acc) | $past(insn[7:0])))
        else $error("or literal wrong");
    a_or_file: assert property (tk && op == IOMB_OP_OR_FILE && d1 |=> file_we && file_wdata == ($past(acc) | $past(file_rdata)))
        else $error("or file wrong");
    a_move_keep: assert property (tk && op == IOMB_OP_MOVE_FILE && d1 |=> file_wdata == $past(file_rdata) && zero_flag == (file_wdata == 8'h00) && $stable(acc))
        else $error("move test wrong");
endmodule : iomb_exec_chk

/* File: verification/iomb_exec_tb_top.sv */
// testbench: directed scenarios for the execute slice
module iomb_exec_tb_top
    import iomb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // =====================================================================
    // stimulus, observed outputs and bookkeeping
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic cyc_en = 1'b0;
    logic insn_valid = 1'b0;
    logic [13:0] insn = 14'h0000;
    logic [7:0] file_rdata = 8'h00;
    logic [7:0] page_latch = 8'h00;
    logic [6:0] file_addr;
    logic [7:0] file_wdata, acc;
    logic [12:0] program_counter;
    logic file_we, zero_flag, squash_next, busy, illegal;
    logic [12:0] pc_exp = 13'h0000;
    int fail_count = 0;
    int compares = 0;
    int cycles = 0;

    iomb_exec u_iomb_exec (.*);

    always #5 clock = ~clock;

    // hang guard: the run needs well under 200 cycles
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 1000) begin
            fail_count++;
            final_report();
        end
    end

    task automatic final_report();
        $display("mismatches %0d compares %0d", fail_count, compares);
        if (fail_count == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report

    task automatic chk(input logic [12:0] got, input logic [12:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // one instruction cycle; even a squashed slot moves pc by one
    task automatic issue(input logic [13:0] w, input logic [7:0] fd);
        @(posedge clock);
        #1;
        insn = w;
        file_rdata = fd;
        cyc_en = 1'b1;
        insn_valid = 1'b1;
        @(posedge clock);
        #1;
        cyc_en = 1'b0;
        pc_exp = pc_exp + 13'h0001;
    endtask : issue

    // architectural state after a slot; write-back judged only when expected
    task automatic st(input logic [7:0] a, input logic z, input logic we, input logic [7:0] wd);
        chk(acc, a);
        chk(zero_flag, z);
        chk(file_we, we);
        chk(program_counter, pc_exp);
        if (we) begin
            chk(file_wdata, wd);
            chk(file_addr, insn[6:0]);
        end
    endtask : st

    task automatic t_logic();
        issue({IOMB_OP_MOVE_FILE, 8'h03}, 8'h00);
        st(8'h00, 1'b1, 1'b0, 8'h00);
        issue({IOMB_OP_OR_LIT, 8'h81}, 8'h00);
        st(8'h81, 1'b0, 1'b0, 8'h00);
        issue({IOMB_OP_OR_FILE, 8'hff}, 8'h42);
        st(8'h81, 1'b0, 1'b1, 8'hc3);
        issue({IOMB_OP_OR_FILE, 8'h00}, 8'h42);
        st(8'hc3, 1'b0, 1'b0, 8'h00);
        issue({IOMB_OP_INC_FILE, 8'h90}, 8'hff);
        st(8'hc3, 1'b1, 1'b1, 8'h00);
        issue({IOMB_OP_INC_FILE, 8'h10}, 8'h7f);
        st(8'h80, 1'b0, 1'b0, 8'h00);
        issue({IOMB_OP_MOVE_FILE, 8'hc4}, 8'h00);
        st(8'h80, 1'b1, 1'b1, 8'h00);
    endtask : t_logic

    // zero skip with the flag already set: flag must stay, one slot lost
    task automatic t_skip();
        issue({IOMB_OP_INC_SKIP, 8'h85}, 8'hff);
        st(8'h80, 1'b1, 1'b1, 8'h00);
        chk(squash_next & busy, 1'b1);
        issue({IOMB_OP_OR_LIT, 8'h7f}, 8'h00);
        st(8'h80, 1'b1, 1'b0, 8'h00);
        issue({IOMB_OP_INC_SKIP, 8'h12}, 8'h41);
        st(8'h42, 1'b1, 1'b0, 8'h00);
        chk(squash_next, 1'b0);
    endtask : t_skip

    // other latch bits set so only bits 4:3 may reach the counter
    task automatic t_branch();
        page_latch = 8'hf7;
        issue({IOMB_OP_BRANCH, 11'h7ff}, 8'h00);
        pc_exp = 13'h17ff;
        st(8'h42, 1'b1, 1'b0, 8'h00);
        chk(busy, 1'b1);
        issue({IOMB_OP_OR_LIT, 8'h01}, 8'h00);
        st(8'h42, 1'b1, 1'b0, 8'h00);
        page_latch = 8'h08;
        issue({IOMB_OP_BRANCH, 11'h000}, 8'h00);
        pc_exp = 13'h0800;
        st(8'h42, 1'b1, 1'b0, 8'h00);
    endtask : t_branch

    // opcode outside the slice: flagged for one slot, state kept, pc still moves
    task automatic t_illegal();
        issue({IOMB_OP_OR_LIT, 8'h00}, 8'h00); // lands in the branch bubble
        st(8'h42, 1'b1, 1'b0, 8'h00);
        chk(illegal, 1'b0);
        issue(14'h0000, 8'h00);
        st(8'h42, 1'b1, 1'b0, 8'h00);
        chk(illegal, 1'b1);
        chk(busy | squash_next, 1'b0);
        issue({IOMB_OP_OR_LIT, 8'h00}, 8'h00);
        st(8'h42, 1'b0, 1'b0, 8'h00);
        chk(illegal, 1'b0);
    endtask : t_illegal

    initial begin
        repeat (8) @(posedge clock);
        #1;
        rst_n = 1'b1;
        st(8'h00, 1'b0, 1'b0, 8'h00);
        t_logic();
        t_skip();
        t_branch();
        t_illegal();
        final_report();
    end
endmodule : iomb_exec_tb_top

bind iomb_exec iomb_exec_chk u_iomb_exec_chk (.*);
